// file: hw/rdp_pkg.sv
/*
 * package for the rom/debug protection control block: register offsets,
 * lock codes, reset values, flash sequencer states and carrier structs.
 * assumes a 32-bit apb master; byte addresses are word aligned.
 */
package rdp_pkg;

    // ************************************************************
    // register map (byte offsets)
    // ************************************************************
    localparam logic [11:0] RDP_ROM_PROT_OFF = 12'h500;
    localparam logic [11:0] RDP_ROM_LOCK_OFF = 12'h504;
    localparam logic [11:0] RDP_DBG_MODE_OFF = 12'h510;
    localparam logic [11:0] RDP_DBG_LOCK_OFF = 12'h514;
    localparam logic [11:0] RDP_STATUS_OFF = 12'h518;
    localparam logic [11:0] RDP_FLASH_CMD_OFF = 12'h51C;

    // ************************************************************
    // fields, codes, reset values
    // ************************************************************
    localparam int RDP_EN_BIT = 0;
    localparam logic [31:0] RDP_ROM_LOCK_CODE = 32'h0000_003D;
    localparam logic [31:0] RDP_DBG_LOCK_CODE = 32'h0000_00C5;
    localparam logic RDP_ROM_EN_RST = 1'b1;
    localparam logic RDP_DBG_OFF_RST = 1'b1;
    localparam logic [31:0] RDP_LOCK_READ_VAL = 32'h0000_0000;
    // flash command codes written to the command register
    localparam logic [1:0] RDP_CMD_SET_BLOCKS = 2'h1;
    localparam logic [1:0] RDP_CMD_RELEASE = 2'h2;
    localparam int RDP_NUM_BLOCKS = 4;
    // flash erase duration in cycles (arbitrary model value)
    localparam logic [7:0] RDP_ERASE_CYCLES = 8'h10;

    typedef enum logic [1:0]
    {
        RDP_FL_IDLE = 2'b00,
        RDP_FL_ERASE = 2'b01,
        RDP_FL_CLEAR = 2'b11
    } rdp_fl_state_t;

    typedef struct packed
    {
        logic rom_prot;
        logic dbg_prot;
        logic flash_prot;
        logic erasing;
    } rdp_status_t;

    typedef struct packed
    {
        logic wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic from_rom;
    } rdp_wreq_t;

endpackage : rdp_pkg

// file: hw/rdp_lock_reg.sv
/*
 * one protect bit with a pending copy that takes effect only when the
 * matching lock code is written. assumes writes already qualified.
 */
module rdp_lock_reg
(
    input wire logic clk,
    input wire logic rst,
    input wire logic keep_on_reset,
    input wire logic rst_val,
    input wire logic wr_bit,
    input wire logic wr_lock,
    input wire logic [31:0] wdata,
    input wire logic [31:0] code,
    input wire logic force_clr,
    output logic pend_q,
    output logic live_q
);
    import rdp_pkg::*;

    logic do_reset;
    assign do_reset = rst & ~keep_on_reset;

    always_ff @(posedge clk)
    begin
        if (do_reset)
            pend_q <= rst_val;
        else if (force_clr)
            pend_q <= 1'b0;
        else if (wr_bit)
            pend_q <= wdata[RDP_EN_BIT];
    end

    // value moves to the live bit only on an exact code
    always_ff @(posedge clk)
    begin
        if (do_reset)
            live_q <= rst_val;
        else if (force_clr)
            live_q <= 1'b0;
        else if (wr_lock && wdata == code)
            live_q <= pend_q;
    end

endmodule : rdp_lock_reg

// file: hw/rdp_flash_seq.sv
/*
 * flash protect state and release sequencer: with all four blocks protected, erase all, then clear
 * protect bits. assumes commands are pre-qualified by the top.
 */
module rdp_flash_seq
(
    input wire logic clk,
    input wire logic por,
    input wire logic cmd_set,
    input wire logic cmd_rel,
    input wire logic [3:0] blk_mask,
    output logic flash_prot,
    output logic erasing,
    output logic erase_done
);
    import rdp_pkg::*;

    rdp_fl_state_t st_q;
    logic [3:0] blk_q;
    logic [7:0] cnt_q;

    assign flash_prot = &blk_q;
    assign erasing = st_q != RDP_FL_IDLE;
    assign erase_done = st_q == RDP_FL_CLEAR;

    always_ff @(posedge clk)
    begin
        if (por)
            st_q <= RDP_FL_IDLE;
        else
            unique case (st_q)
                RDP_FL_IDLE:
                    if (cmd_rel && flash_prot)
                        st_q <= RDP_FL_ERASE;
                RDP_FL_ERASE:
                    if (cnt_q == RDP_ERASE_CYCLES)
                        st_q <= RDP_FL_CLEAR;
                RDP_FL_CLEAR:
                    st_q <= RDP_FL_IDLE;
                default:
                    st_q <= RDP_FL_IDLE;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (por || st_q != RDP_FL_ERASE)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // with all four blocks protected, protect bits clear only after the erase has finished
    always_ff @(posedge clk)
    begin
        if (por)
            blk_q <= 4'h0;
        else if (st_q == RDP_FL_CLEAR)
            blk_q <= 4'h0;
        else if (cmd_rel && !flash_prot && st_q == RDP_FL_IDLE)
            blk_q <= 4'h0;
        else if (cmd_set && st_q == RDP_FL_IDLE)
            blk_q <= blk_q | blk_mask;
    end

endmodule : rdp_flash_seq

// file: hw/rdp_ctrl.sv
/*
 * apb slave for rom data and debug protection control. holds the
 * protect bits, their lock registers, and the flash protect sequencer.
 * assumes por_rst is a synchronous power-on reset, rst an ordinary
 * synchronous reset, and fetch_from_rom is valid during the apb access.
 */
// Local design decisions: the APB slave port and the register offsets.
// Overview of operation
// - rom protect enable resets to one
// - rom protection equals flash protect and enable
// - clear bit, write 0x3D lock to lift
// - set bit, write 0x3D lock to restore
// - protected: only rom-fetched writes change rom regs
// - lock registers are write-only, read zero
// - flash: por only resets; mask: every reset
// - debug disable bit resets to one
// - debug protection equals flash protect and disable
// - clear bit, write 0xC5 lock to lift
// - set bit, write 0xC5 lock to restore
// - protected: only rom-fetched writes change debug regs
// - debug unit blocked while protected
// - flash protect needs all four blocks protected
// - mask: flash protect always in force
// - release erases flash, then clears bits; without all four blocks protected it clears bits at once
// - flash commands ignored under rom protection
// - release while protected initializes whole flash
// - mask: debug bit rewrites have no effect
module rdp_ctrl
(
    input wire logic clk,
    input wire logic rst,
    input wire logic por_rst,
    input wire logic mask_version,
    input wire logic fetch_from_rom,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic rom_protect_q,
    output logic debug_unit_block_q,
    output logic flash_protect_q,
    output logic flash_erase_busy_q
);
    import rdp_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    rdp_wreq_t req;
    logic access;
    logic full_word;
    logic allowed;
    logic wr_ok;
    logic mapped;
    logic rom_prot;
    logic rom_en_pend;
    logic rom_en_live;
    logic dbg_off_pend;
    logic dbg_off_live;
    logic flash_prot_raw;
    logic flash_prot;
    logic erasing;
    logic erase_done;
    logic por_any;
    rdp_status_t status;
    logic [31:0] rdata_d;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = a == o;
    endfunction : hit

    assign access = psel & penable;
    assign full_word = pstrb == 4'hF;
    assign req.wr = access & pwrite & ~pready;
    assign req.addr = paddr;
    assign req.data = pwdata;
    assign req.from_rom = fetch_from_rom;
    assign mapped = hit(paddr, RDP_ROM_PROT_OFF) |
        hit(paddr, RDP_ROM_LOCK_OFF) | hit(paddr, RDP_DBG_MODE_OFF) |
        hit(paddr, RDP_DBG_LOCK_OFF) | hit(paddr, RDP_STATUS_OFF) |
        hit(paddr, RDP_FLASH_CMD_OFF);

    // protected state gates writes to origin in rom
    assign allowed = ~rom_prot | req.from_rom;
    // narrow writes are refused with an error
    assign wr_ok = req.wr & full_word & allowed;

    // ************************************************************
    // protection state
    // ************************************************************
    assign por_any = por_rst | (rst & mask_version);

    rdp_flash_seq u_flash
    (
        .clk(clk),
        .por(por_any),
        .cmd_set(wr_ok & hit(req.addr, RDP_FLASH_CMD_OFF) &
            (req.data[1:0] == RDP_CMD_SET_BLOCKS) & ~mask_version &
            ~rom_prot),
        .cmd_rel(wr_ok & hit(req.addr, RDP_FLASH_CMD_OFF) &
            (req.data[1:0] == RDP_CMD_RELEASE) & ~mask_version &
            ~rom_prot),
        .blk_mask(req.data[7:4]),
        .flash_prot(flash_prot_raw),
        .erasing(erasing),
        .erase_done(erase_done)
    );

    // mask parts are always flash protected; flash needs all blocks
    assign flash_prot = mask_version | flash_prot_raw;

    rdp_lock_reg u_rom_bit
    (
        .clk(clk),
        .rst(por_any | rst),
        .keep_on_reset(~por_any),
        .rst_val(RDP_ROM_EN_RST),
        .wr_bit(wr_ok & hit(req.addr, RDP_ROM_PROT_OFF)),
        .wr_lock(wr_ok & hit(req.addr, RDP_ROM_LOCK_OFF)),
        .wdata(req.data),
        .code(RDP_ROM_LOCK_CODE),
        .force_clr(1'b0),
        .pend_q(rom_en_pend),
        .live_q(rom_en_live)
    );

    // debug bits cannot be rewritten on mask parts
    rdp_lock_reg u_dbg_bit
    (
        .clk(clk),
        .rst(por_any | rst),
        .keep_on_reset(~por_any),
        .rst_val(RDP_DBG_OFF_RST),
        .wr_bit(wr_ok & hit(req.addr, RDP_DBG_MODE_OFF) &
            ~mask_version),
        .wr_lock(wr_ok & hit(req.addr, RDP_DBG_LOCK_OFF) &
            ~mask_version),
        .wdata(req.data),
        .code(RDP_DBG_LOCK_CODE),
        .force_clr(1'b0),
        .pend_q(dbg_off_pend),
        .live_q(dbg_off_live)
    );

    assign rom_prot = flash_prot & rom_en_live;

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (por_rst)
        begin
            rom_protect_q <= 1'b1;
            debug_unit_block_q <= 1'b1;
            flash_protect_q <= 1'b0;
            flash_erase_busy_q <= 1'b0;
        end
        else
        begin
            rom_protect_q <= rom_prot;
            debug_unit_block_q <= flash_prot & dbg_off_live;
            flash_protect_q <= flash_prot;
            flash_erase_busy_q <= erasing;
        end
    end

    assign status.rom_prot = rom_prot;
    assign status.dbg_prot = flash_prot & dbg_off_live;
    assign status.flash_prot = flash_prot;
    assign status.erasing = erasing;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (hit(paddr, RDP_ROM_PROT_OFF))
            rdata_d[RDP_EN_BIT] = rom_en_pend;
        else if (hit(paddr, RDP_DBG_MODE_OFF))
            rdata_d[RDP_EN_BIT] = dbg_off_pend;
        else if (hit(paddr, RDP_STATUS_OFF))
            rdata_d[3:0] = status;
        else
            rdata_d = RDP_LOCK_READ_VAL;
    end

    // one wait state: pready rises on the second access cycle
    always_ff @(posedge clk)
    begin
        if (rst || por_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (access && !pready)
        begin
            pready <= 1'b1;
            pslverr <= ~mapped | (pwrite & ~full_word);
            prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // outputs still show their reset value one edge after power-on reset
    chk_rom_prot_def: assert property (
        @(posedge clk) disable iff (por_rst)
        !$past(por_rst) |-> rom_protect_q == $past(flash_prot & rom_en_live))
        else $error("rom protect output mismatch");

    chk_dbg_block: assert property (
        @(posedge clk) disable iff (por_rst) !$past(por_rst) |->
        debug_unit_block_q == $past(flash_prot & dbg_off_live))
        else $error("debug block output mismatch");

    chk_mask_flash: assert property (
        @(posedge clk) disable iff (por_rst)
        mask_version |-> flash_prot)
        else $error("mask part not flash protected");

    chk_no_prot_flash: assert property (
        @(posedge clk) disable iff (por_rst)
        !flash_prot |-> !rom_prot && !status.dbg_prot)
        else $error("protection without flash protect");

    chk_por_values: assert property (
        @(posedge clk)
        por_rst |=> rom_en_live && dbg_off_live)
        else $error("protect bits not set after reset");

    chk_mask_reset: assert property (
        @(posedge clk)
        (rst && mask_version) |=> rom_en_live && dbg_off_live)
        else $error("mask part kept bits over reset");

    chk_rst_keeps: assert property (
        @(posedge clk) disable iff (por_rst)
        (rst && !mask_version && !access) |=>
        $stable(rom_en_live) && $stable(dbg_off_live))
        else $error("ordinary reset changed protect bits");

    // ************************************************************
    // lock and origin checks
    // ************************************************************

    chk_bad_code: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (wr_ok && hit(paddr, RDP_ROM_LOCK_OFF) &&
        pwdata != RDP_ROM_LOCK_CODE) |=> $stable(rom_en_live))
        else $error("wrong rom code changed state");

    chk_bad_dbg_code: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (wr_ok && hit(paddr, RDP_DBG_LOCK_OFF) &&
        pwdata != RDP_DBG_LOCK_CODE) |=> $stable(dbg_off_live))
        else $error("wrong debug code changed state");

    chk_good_rom_code: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (wr_ok && hit(paddr, RDP_ROM_LOCK_OFF) &&
        pwdata == RDP_ROM_LOCK_CODE) |=> rom_en_live == $past(rom_en_pend))
        else $error("rom code not applied");

    chk_good_code: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (wr_ok && !mask_version && hit(paddr, RDP_DBG_LOCK_OFF) &&
        pwdata == RDP_DBG_LOCK_CODE) |=> dbg_off_live == $past(dbg_off_pend))
        else $error("debug code not applied");

    chk_origin_gate: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (req.wr && rom_prot && !fetch_from_rom) |=>
        $stable(rom_en_pend) && $stable(rom_en_live))
        else $error("non-rom write accepted");

    chk_dbg_origin: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (req.wr && rom_prot && !fetch_from_rom) |=>
        $stable(dbg_off_pend) && $stable(dbg_off_live))
        else $error("non-rom debug write accepted");

    chk_mask_fixed: assert property (
        @(posedge clk) disable iff (por_any)
        mask_version |=> $stable(dbg_off_pend) && $stable(dbg_off_live))
        else $error("mask part debug bit rewritten");

    // ************************************************************
    // flash sequencer checks
    // ************************************************************

    // busy cycles of the current erase, for the length check
    logic [7:0] busy_cnt_q;

    always_ff @(posedge clk)
    begin
        if (por_any || !erasing)
            busy_cnt_q <= 8'h00;
        else
            busy_cnt_q <= busy_cnt_q + 8'h01;
    end

    chk_flash_cmd_gate: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (rom_prot && !erasing && req.wr && hit(paddr, RDP_FLASH_CMD_OFF))
        |=> !erasing)
        else $error("flash command ran under rom protection");

    chk_clear_after_erase: assert property (
        @(posedge clk) disable iff (por_any)
        (!$past(por_any) && $fell(flash_prot_raw)) |-> $past(erase_done))
        else $error("protect bits cleared before erase");

    // busy spans the full count, its last compare and the clear cycle
    chk_erase_length: assert property (
        @(posedge clk) disable iff (por_any)
        (!$past(por_any) && $fell(erasing)) |->
        busy_cnt_q == RDP_ERASE_CYCLES + 8'h02)
        else $error("erase did not run its full length");

    // ************************************************************
    // bus protocol checks
    // ************************************************************

    chk_ready_pulse: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    chk_narrow_error: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (access && !pready && pwrite && pstrb != 4'hF) |=> pready && pslverr)
        else $error("narrow write not refused");

    chk_lock_read: assert property (
        @(posedge clk) disable iff (rst | por_rst)
        (access && !pwrite && !pready && hit(paddr, RDP_DBG_LOCK_OFF))
        |=> prdata == RDP_LOCK_READ_VAL)
        else $error("lock register read not zero");

    cov_rom_lift: cover property (@(posedge clk) $fell(rom_protect_q));
    cov_dbg_lift: cover property (@(posedge clk) $fell(debug_unit_block_q));
    cov_erase: cover property (@(posedge clk) $rose(flash_erase_busy_q));
    cov_mask_lift: cover property (@(posedge clk)
        mask_version && $fell(rom_protect_q));
    cov_wrong_code: cover property (@(posedge clk)
        wr_ok && hit(paddr, RDP_ROM_LOCK_OFF) && pwdata != RDP_ROM_LOCK_CODE);

endmodule : rdp_ctrl

// file: tb/rdp_tb.sv
/*
 * self-checking bench for the rom/debug protection control block.
 * assumes the rdp_pkg map and the one-wait-state apb slave of rdp_ctrl.
 */
module tb import rdp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // signals and helpers
    // ************************************************************
    logic clk, rst, por_rst, mask_version, fetch_from_rom;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0] pstrb;
    logic rom_protect_q, debug_unit_block_q;
    logic flash_protect_q, flash_erase_busy_q;
    logic er;
    int fail_count, tests_run, n;

    rdp_ctrl dut
    (
        .clk(clk), .rst(rst), .por_rst(por_rst),
        .mask_version(mask_version), .fetch_from_rom(fetch_from_rom),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .rom_protect_q(rom_protect_q),
        .debug_unit_block_q(debug_unit_block_q),
        .flash_protect_q(flash_protect_q),
        .flash_erase_busy_q(flash_erase_busy_q)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF);
        chk("prdata", rd, e);
    endtask : rdchk

    // outputs as {rom, debug, flash, erasing}
    task automatic look(input logic [3:0] e);
        @(negedge clk);
        chk("outputs", {28'h0, rom_protect_q, debug_unit_block_q,
            flash_protect_q, flash_erase_busy_q}, {28'h0, e});
        @(posedge clk);
    endtask : look

    task automatic pulse_reset(input logic p);
        if (p)
            por_rst <= 1'b1;
        else
            rst <= 1'b1;
        repeat (4) @(posedge clk);
        por_rst <= 1'b0;
        rst <= 1'b0;
        @(posedge clk);
    endtask : pulse_reset

    task automatic wrong(input logic [11:0] a, input logic [31:0] c);
        do
            seed = lfsr(seed);
        while (seed == c);
        wr(a, seed);
    endtask : wrong

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    initial
    begin
        rst <= 1'b0;
        por_rst <= 1'b1;
        mask_version <= 1'b0;
        fetch_from_rom <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h0;
        pwdata <= 32'h0;
        pstrb <= 4'hF;
        seed = 32'h66A5245A;
        fail_count = 0;
        tests_run = 0;
        @(posedge clk);
        pulse_reset(1'b1);
        look(4'b0000);
        rdchk(RDP_ROM_PROT_OFF, 32'h1);
        rdchk(RDP_DBG_MODE_OFF, 32'h1);
        wr(RDP_ROM_LOCK_OFF, 32'h3D);
        rdchk(RDP_ROM_LOCK_OFF, RDP_LOCK_READ_VAL);
        wr(RDP_DBG_LOCK_OFF, 32'hC5);
        rdchk(RDP_DBG_LOCK_OFF, RDP_LOCK_READ_VAL);
        wr(RDP_FLASH_CMD_OFF, 32'h71);
        look(4'b0000);
        wr(RDP_FLASH_CMD_OFF, 32'hF1);
        look(4'b1110);
        wr(RDP_ROM_PROT_OFF, 32'h0);
        wr(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
        look(4'b1110);
        rdchk(RDP_ROM_PROT_OFF, 32'h1);
        wr(RDP_DBG_MODE_OFF, 32'h0);
        wr(RDP_DBG_LOCK_OFF, RDP_DBG_LOCK_CODE);
        look(4'b1110);
        wr(RDP_FLASH_CMD_OFF, 32'h2);
        look(4'b1110);
        fetch_from_rom <= 1'b1;
        wr(RDP_ROM_PROT_OFF, 32'h0);
        repeat (3)
        begin
            wrong(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
            look(4'b1110);
        end
        wr(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
        look(4'b0110);
        wr(RDP_DBG_MODE_OFF, 32'h0);
        wrong(RDP_DBG_LOCK_OFF, RDP_DBG_LOCK_CODE);
        look(4'b0110);
        wr(RDP_DBG_LOCK_OFF, RDP_DBG_LOCK_CODE);
        look(4'b0010);
        pulse_reset(1'b0);
        look(4'b0010);
        rdchk(RDP_DBG_MODE_OFF, 32'h0);
        wr(RDP_DBG_MODE_OFF, 32'h1);
        wr(RDP_DBG_LOCK_OFF, RDP_DBG_LOCK_CODE);
        look(4'b0110);
        wr(RDP_ROM_PROT_OFF, 32'h1);
        wr(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
        look(4'b1110);
        wr(RDP_ROM_PROT_OFF, 32'h0);
        wr(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
        look(4'b0110);
        wr(RDP_FLASH_CMD_OFF, 32'h2);
        look(4'b0111);
        n = 0;
        while (flash_erase_busy_q !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        look(4'b0000);
        apb(1'b0, 12'h5F0, 32'h0, 4'hF);
        chk("pslverr", {31'h0, er}, 32'h1);
        seed = lfsr(seed);
        apb(1'b1, RDP_ROM_PROT_OFF, seed, 4'h3);
        chk("pslverr", {31'h0, er}, 32'h1);
        mask_version <= 1'b1;
        pulse_reset(1'b1);
        look(4'b1110);
        wr(RDP_DBG_MODE_OFF, 32'h0);
        wr(RDP_DBG_LOCK_OFF, RDP_DBG_LOCK_CODE);
        look(4'b1110);
        wr(RDP_ROM_PROT_OFF, 32'h0);
        wr(RDP_ROM_LOCK_OFF, RDP_ROM_LOCK_CODE);
        look(4'b0110);
        pulse_reset(1'b0);
        look(4'b1110);
        stop_test();
    end
endmodule : tb
